// ===== src/vcm_mode_ctrl.sv
`timescale 1ns/1ps

// How it works
// - The resonance code maps to 50..150 Hz in 1 Hz steps through a non-decreasing table.
// - A serial clock held low for the stated time sends the block to shutdown from any mode.
// - In shutdown everything but the serial clock going high is ignored.
// - A rising serial clock in shutdown moves to standby and loads every default.
// - In standby, register writes from the serial engine are accepted.
// - A zero current setpoint means standby with the output stage off.
// - Setting the soft reset bit returns to standby and restores all defaults.
// - In active mode an over-temperature, coil short or coil open fault drops to standby.
// - A fault fallback clears the current setpoint.
// - A nonzero current setpoint written by the host enters active mode.
// - In active mode the output stage stays enabled until an exit condition.
// - Entering active mode again after a fault clears the status register.
// - The soft reset bit clears itself and reads back as zero.
module vcm_mode_ctrl
	import vcm_mode_pkg::*;
#(
	parameter int CURRENT_W  = 10,
	parameter int LOW_CYCLES = SCL_LOW_CYCLES
) (
	input  wire logic           clk,
	input  wire logic           reset_n,
	input  wire logic           scl_pin,
	input  wire reg_req_t       reg_req,
	input  wire fault_t         faults,
	output logic [7:0]          reg_rdata,
	output logic                reg_rvalid,
	output op_mode_t            mode,
	output logic                driver_enable,
	output logic [CURRENT_W-1:0] current_setpoint,
	output logic                ring_enable,
	output logic [7:0]          mode_config,
	output logic [7:0]          resonance_frequency_code,
	output logic [7:0]          resonance_hz,
	output logic [2:0]          status
);

	// Counter just wide enough for the whole low time, so it never wraps
	localparam int CNT_W = $clog2(LOW_CYCLES + 1);
	localparam logic [CNT_W-1:0] LOW_LAST = CNT_W'(LOW_CYCLES - 1);

	// Frequency in Hz: one step for every table entry not above the code
	function automatic logic [7:0] code_to_hz(input logic [7:0] code);
		logic [7:0] hz;
		hz = 8'(RES_FREQ_MIN_HZ - 1);
		for (int i = 0; i < RES_TABLE_LEN; i++) begin
			if (code >= RES_CODE_TABLE[i]) begin
				hz = hz + 8'h01;
			end
		end
		return hz;
	endfunction

	// Whole byte as read back on the register port
	function automatic logic [7:0] status_byte(input logic [2:0] s);
		return {5'h00, s};
	endfunction

	// Filtered serial clock and its low-time counter
	logic                 scl_level;
	logic                 scl_prev;
	logic                 next_scl_prev;
	logic                 scl_rise;
	logic [CNT_W-1:0]     low_count;
	logic [CNT_W-1:0]     next_low_count;
	logic                 low_expired;

	// Next values of the registered outputs and the helpers that steer them
	op_mode_t             next_mode;
	logic                 next_driver_enable;
	logic [CURRENT_W-1:0] next_current;
	logic                 next_ring_enable;
	logic [7:0]           next_mode_config;
	logic [7:0]           next_freq_code;
	logic [7:0]           next_hz;
	logic [2:0]           next_status;
	logic                 fault_seen;
	logic                 next_fault_seen;
	logic [7:0]           next_rdata;
	logic                 next_rvalid;
	logic                 any_fault;
	logic                 soft_reset_req;
	logic [2:0]           fault_bits;

	// Serial clock comes from the host's domain
	pin_sync u_scl_sync (
		.clk         (clk),
		.reset_n     (reset_n),
		.pin         (scl_pin),
		.level       (scl_level)
	);

	// Low-time counter on the local clock; saturates so it never wraps
	always_comb begin
		next_scl_prev = scl_level;
		// Edge taken from the filtered level, so pin bounce cannot wake the block
		scl_rise      = scl_level && !scl_prev;
		if (scl_level) begin
			next_low_count = '0;
		end else if (low_count != LOW_LAST) begin
			next_low_count = low_count + CNT_W'(1);
		end else begin
			next_low_count = low_count;
		end
		low_expired = !scl_level && (low_count == LOW_LAST);
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			scl_prev  <= 1'b1;
			low_count <= '0;
		end else begin
			scl_prev  <= next_scl_prev;
			low_count <= next_low_count;
		end
	end

	// Decoded requests and fault summary
	assign fault_bits = {faults.coil_open_fault, faults.coil_short_fault,
		faults.over_temperature_fault};
	assign any_fault = |fault_bits;
	// Soft reset acts on the write strobe itself and is never stored
	assign soft_reset_req = reg_req.wr && (reg_req.addr == REG_CONTROL)
		&& reg_req.wdata[CTRL_SOFT_RESET_BIT];

	// Mode and register state; shutdown, then low time, then soft reset, then faults
	always_comb begin
		next_mode        = mode;
		next_current     = current_setpoint;
		next_ring_enable = ring_enable;
		next_mode_config = mode_config;
		next_freq_code   = resonance_frequency_code;
		next_status      = status;
		next_fault_seen  = fault_seen;
		unique case (mode)
			MODE_SHUTDOWN: begin
				// Writes, reads and faults are not looked at while asleep
				// wait for clock high
				if (scl_rise) begin
					next_mode        = MODE_STANDBY;
					next_current     = '0;
					next_ring_enable = CONTROL_RESET[CTRL_RING_BIT];
					next_mode_config = MODE_RESET;
					next_freq_code   = RES_FREQ_RESET;
					next_status      = STATUS_RESET[2:0];
					next_fault_seen  = 1'b0;
				end
			end
			MODE_STANDBY, MODE_ACTIVE: begin
				if (low_expired) begin
					next_mode = MODE_SHUTDOWN;
				end else if (soft_reset_req) begin
					next_mode        = MODE_STANDBY;
					next_current     = '0;
					next_ring_enable = CONTROL_RESET[CTRL_RING_BIT];
					next_mode_config = MODE_RESET;
					next_freq_code   = RES_FREQ_RESET;
					next_status      = STATUS_RESET[2:0];
					next_fault_seen  = 1'b0;
				end else if (mode == MODE_ACTIVE && any_fault) begin
					next_mode       = MODE_STANDBY;
					next_current    = '0;
					// Cause of the drop stays visible until active is entered again
					next_status     = status | fault_bits;
					next_fault_seen = 1'b1;
				end else begin
					// Writes that lose to a higher event in this cycle are dropped
					// accept register writes
					if (reg_req.wr) begin
						unique case (reg_req.addr)
							REG_CONTROL: begin
								next_ring_enable = reg_req.wdata[CTRL_RING_BIT];
							end
							REG_CURRENT_MSB: begin
								next_current[CURRENT_W-1 -: CURRENT_MSB_BITS] =
									reg_req.wdata[CURRENT_MSB_BITS-1:0];
							end
							REG_CURRENT_LSB: begin
								next_current[7:0] = reg_req.wdata;
							end
							REG_MODE: begin
								next_mode_config = reg_req.wdata;
							end
							REG_RES_FREQ: begin
								next_freq_code = reg_req.wdata;
							end
							default: begin
								// Status is read-only; other offsets drop the write
							end
						endcase
					end
					if (next_current != '0) begin
						next_mode = MODE_ACTIVE;
						if (mode != MODE_ACTIVE && fault_seen) begin
							next_status     = STATUS_RESET[2:0];
							next_fault_seen = 1'b0;
						end
					end else begin
						next_mode = MODE_STANDBY;
					end
					// Fault bits are ORed in only when already active; at re-entry the clear wins
					if (mode == MODE_ACTIVE) begin
						next_status = next_status | fault_bits;
					end
				end
			end
			default: begin
				// An unused code recovers to standby rather than locking up
				next_mode = MODE_STANDBY;
			end
		endcase
		next_driver_enable = (next_mode == MODE_ACTIVE);
		// Decoded from the next code so Hz and code change on the same edge
		// table lookup
		next_hz = code_to_hz(next_freq_code);
	end

	// Registered state; reset lands in standby with defaults loaded
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			mode                     <= MODE_STANDBY;
			driver_enable            <= 1'b0;
			current_setpoint         <= '0;
			ring_enable              <= CONTROL_RESET[CTRL_RING_BIT];
			mode_config              <= MODE_RESET;
			resonance_frequency_code <= RES_FREQ_RESET;
			resonance_hz             <= 8'h00;
			status                   <= STATUS_RESET[2:0];
			fault_seen               <= 1'b0;
		end else begin
			mode                     <= next_mode;
			driver_enable            <= next_driver_enable;
			current_setpoint         <= next_current;
			ring_enable              <= next_ring_enable;
			mode_config              <= next_mode_config;
			resonance_frequency_code <= next_freq_code;
			resonance_hz             <= next_hz;
			status                   <= next_status;
			fault_seen               <= next_fault_seen;
		end
	end

	// Read path; shutdown gives no answer at all
	// A read in the same cycle as a write returns the old value
	always_comb begin
		next_rdata  = reg_rdata;
		next_rvalid = 1'b0;
		if (reg_req.rd && mode != MODE_SHUTDOWN) begin
			next_rvalid = 1'b1;
			unique case (reg_req.addr)
				REG_CONTROL: begin
					next_rdata = {6'h00, ring_enable, 1'b0};
				end
				REG_CURRENT_MSB: begin
					next_rdata = {6'h00, current_setpoint[CURRENT_W-1 -: CURRENT_MSB_BITS]};
				end
				REG_CURRENT_LSB: begin
					next_rdata = current_setpoint[7:0];
				end
				REG_STATUS: begin
					next_rdata = status_byte(status);
				end
				REG_MODE: begin
					next_rdata = mode_config;
				end
				REG_RES_FREQ: begin
					next_rdata = resonance_frequency_code;
				end
				default: begin
					next_rdata = 8'h00;
				end
			endcase
		end
	end

	// Read answer; rvalid is a one-cycle pulse, rdata holds until the next read
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata  <= 8'h00;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rdata  <= next_rdata;
			reg_rvalid <= next_rvalid;
		end
	end

endmodule // vcm_mode_ctrl

// ===== src/vcm_mode_pkg.sv
package vcm_mode_pkg;

	// Register offsets on the serial register port
	localparam logic [7:0] REG_CONTROL     = 8'h02;
	localparam logic [7:0] REG_CURRENT_MSB = 8'h03;
	localparam logic [7:0] REG_CURRENT_LSB = 8'h04;
	localparam logic [7:0] REG_STATUS      = 8'h05;
	localparam logic [7:0] REG_MODE        = 8'h06;
	localparam logic [7:0] REG_RES_FREQ    = 8'h07;

	// Values after reset and after any return to defaults
	localparam logic [7:0] CONTROL_RESET   = 8'h02;
	localparam logic [7:0] CURRENT_RESET   = 8'h00;
	localparam logic [7:0] STATUS_RESET    = 8'h00;
	localparam logic [7:0] MODE_RESET      = 8'h00;
	localparam logic [7:0] RES_FREQ_RESET  = 8'h83;

	// Field positions
	localparam int CTRL_SOFT_RESET_BIT = 0;
	localparam int CTRL_RING_BIT       = 1;
	localparam int STAT_OVER_TEMP_BIT  = 0;
	localparam int STAT_SHORT_BIT      = 1;
	localparam int STAT_OPEN_BIT       = 2;
	localparam int CURRENT_MSB_BITS    = 2;

	// Serial clock low time before shutdown
	localparam int CLK_PERIOD_NS    = 8;
	localparam int SCL_LOW_TIME_NS  = 500000;
	localparam int SCL_LOW_CYCLES   = (SCL_LOW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Resonance frequency table: lowest code of each 1 Hz step from 50 Hz upward
	localparam int RES_FREQ_MIN_HZ = 50;
	localparam int RES_TABLE_LEN   = 101;
	localparam logic [7:0] RES_CODE_TABLE [0:RES_TABLE_LEN-1] = '{
		8'h00, 8'h07, 8'h0e, 8'h15, 8'h1b, 8'h22, 8'h28, 8'h2e, 8'h34, 8'h3a,
		8'h3f, 8'h44, 8'h49, 8'h4e, 8'h53, 8'h58, 8'h5c, 8'h60, 8'h65, 8'h69,
		8'h6d, 8'h71, 8'h74, 8'h78, 8'h7c, 8'h7f, 8'h82, 8'h86, 8'h89, 8'h8c,
		8'h8f, 8'h92, 8'h95, 8'h98, 8'h9a, 8'h9d, 8'ha0, 8'ha2, 8'ha5, 8'ha7,
		8'haa, 8'hac, 8'hae, 8'hb1, 8'hb3, 8'hb5, 8'hb7, 8'hb9, 8'hbb, 8'hbd,
		8'hbf, 8'hc1, 8'hc3, 8'hc5, 8'hc6, 8'hc8, 8'hca, 8'hcc, 8'hcd, 8'hcf,
		8'hd0, 8'hd2, 8'hd4, 8'hd5, 8'hd7, 8'hd8, 8'hd9, 8'hdb, 8'hdc, 8'hde,
		8'hdf, 8'he0, 8'he2, 8'he3, 8'he4, 8'he5, 8'he7, 8'he8, 8'he9, 8'hea,
		8'heb, 8'hec, 8'hee, 8'hef, 8'hf0, 8'hf1, 8'hf2, 8'hf3, 8'hf4, 8'hf5,
		8'hf6, 8'hf7, 8'hf8, 8'hf9, 8'hfa, 8'hfb, 8'hfb, 8'hfc, 8'hfd, 8'hfe,
		8'hff
	};

	// Operating modes
	typedef enum logic [1:0] {
		MODE_SHUTDOWN = 2'b00,
		MODE_STANDBY  = 2'b01,
		MODE_ACTIVE   = 2'b10
	} op_mode_t;

	// Register access from the serial engine
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	// Fault levels from the analog protection
	typedef struct packed {
		logic over_temperature_fault;
		logic coil_short_fault;
		logic coil_open_fault;
	} fault_t;

endpackage

// ===== src/pin_sync.sv
`timescale 1ns/1ps

// Three-stage pin synchroniser; output moves only when stages two and three agree
module pin_sync (
	input  wire logic clk,
	input  wire logic reset_n,
	input  wire logic pin,
	output logic      level
);

	logic [2:0] stage;
	logic [2:0] next_stage;
	logic       next_level;

	// Shift the pin in; the first stage feeds only the second
	always_comb begin
		next_stage = {stage[1:0], pin};
		next_level = (stage[1] == stage[2]) ? stage[2] : level;
	end

	// Reset value is held high: an idle serial clock line
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			stage <= 3'h7;
			level <= 1'b1;
		end else begin
			stage <= next_stage;
			level <= next_level;
		end
	end

endmodule // pin_sync

// ===== tb/vcm_mode_ctrl_props.sv
`timescale 1ns/1ps

// Port-level watch over modes, faults and the serial clock low timer
module vcm_mode_ctrl_props
	import vcm_mode_pkg::*;
#(
	parameter int CURRENT_W  = 10,
	parameter int LOW_CYCLES = SCL_LOW_CYCLES
) (
	input wire logic                 clk,
	input wire logic                 reset_n,
	input wire logic                 scl_pin,
	input wire reg_req_t             reg_req,
	input wire fault_t               faults,
	input wire logic [7:0]           reg_rdata,
	input wire logic                 reg_rvalid,
	input wire op_mode_t             mode,
	input wire logic                 driver_enable,
	input wire logic [CURRENT_W-1:0] current_setpoint,
	input wire logic                 ring_enable,
	input wire logic [7:0]           mode_config,
	input wire logic [7:0]           resonance_frequency_code,
	input wire logic [7:0]           resonance_hz,
	input wire logic [2:0]           status
);
	int low_cnt;
	int next_low_cnt;

	// Raw pin low time; saturates so a long park cannot wrap
	always_comb begin
		next_low_cnt = scl_pin ? 0 : (low_cnt > LOW_CYCLES + 9 ? low_cnt : low_cnt + 1);
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			low_cnt <= 0;
		end else begin
			low_cnt <= next_low_cnt;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	AST_LOW_MAX: assert property (low_cnt > LOW_CYCLES + 6 |-> mode == MODE_SHUTDOWN)
		else $error("no shutdown after long low");
	AST_LOW_MIN: assert property (mode != MODE_SHUTDOWN ##1 mode == MODE_SHUTDOWN |-> low_cnt >= LOW_CYCLES)
		else $error("shutdown too early");
	AST_SHUT_HOLD: assert property ((mode == MODE_SHUTDOWN && !scl_pin) [*8] |=> mode == MODE_SHUTDOWN)
		else $error("left shutdown while low");
	AST_SHUT_NO_READ: assert property (reg_req.rd && mode == MODE_SHUTDOWN |=> !reg_rvalid)
		else $error("read answered in shutdown");
	AST_WAKE: assert property ($rose(scl_pin) && mode == MODE_SHUTDOWN ##1 scl_pin [*7] |-> ##[0:4] mode == MODE_STANDBY)
		else $error("no wake on high");
	AST_WAKE_DEFAULTS: assert property ($fell(mode == MODE_SHUTDOWN) |-> mode == MODE_STANDBY && ring_enable && resonance_frequency_code == RES_FREQ_RESET && current_setpoint == '0)
		else $error("wake without defaults");
	AST_ZERO_STANDBY: assert property (mode != MODE_SHUTDOWN |-> (current_setpoint != '0) == (mode == MODE_ACTIVE))
		else $error("mode and setpoint disagree");
	AST_DRV_MODE: assert property (driver_enable == (mode == MODE_ACTIVE))
		else $error("driver enable off mode");
	AST_WR_ACTIVE: assert property (reg_req.wr && reg_req.addr == REG_CURRENT_LSB && reg_req.wdata != 8'h00 && mode == MODE_STANDBY |=> mode == MODE_ACTIVE)
		else $error("nonzero write not active");
	AST_FAULT_DROP: assert property (mode == MODE_ACTIVE && faults != '0 |=> mode == MODE_STANDBY && current_setpoint == '0)
		else $error("fault did not drop");
	AST_SOFT_RESET: assert property (reg_req.wr && reg_req.addr == REG_CONTROL && reg_req.wdata[0] && mode != MODE_SHUTDOWN |=> mode == MODE_STANDBY && resonance_frequency_code == RES_FREQ_RESET)
		else $error("soft reset missed");
	AST_SOFT_BIT_READ: assert property (reg_req.rd && reg_req.addr == REG_CONTROL && mode != MODE_SHUTDOWN |=> reg_rvalid && !reg_rdata[0])
		else $error("soft reset bit reads one");
	AST_REENTRY_CLEAR: assert property (mode == MODE_STANDBY && faults == '0 ##1 mode == MODE_ACTIVE |-> status == 3'h0)
		else $error("status kept on entry");
	AST_FREQ_TOP: assert property (resonance_frequency_code == 8'hff |-> resonance_hz == 8'h96)
		else $error("top code not 150 Hz");

	COV_SHUTDOWN: cover property (mode == MODE_SHUTDOWN);
	COV_FAULT: cover property (mode == MODE_ACTIVE && faults != '0);
	COV_SOFT: cover property (reg_req.wr && reg_req.addr == REG_CONTROL && reg_req.wdata[0]);
endmodule // vcm_mode_ctrl_props

bind vcm_mode_ctrl vcm_mode_ctrl_props #(
	.CURRENT_W  (CURRENT_W),
	.LOW_CYCLES (LOW_CYCLES)
) props (
	.clk                      (clk),
	.reset_n                  (reset_n),
	.scl_pin                  (scl_pin),
	.reg_req                  (reg_req),
	.faults                   (faults),
	.reg_rdata                (reg_rdata),
	.reg_rvalid               (reg_rvalid),
	.mode                     (mode),
	.driver_enable            (driver_enable),
	.current_setpoint         (current_setpoint),
	.ring_enable              (ring_enable),
	.mode_config              (mode_config),
	.resonance_frequency_code (resonance_frequency_code),
	.resonance_hz             (resonance_hz),
	.status                   (status)
);

// ===== tb/scl_host_model.sv
`timescale 1ns/1ps

// Host serial clock: toggles in frames, rests high, or is parked low
module scl_host_model (
	input wire logic run,
	input wire logic park,
	output logic     scl
);
	// Start offset puts every link change 1 ns after a rising edge of the block clock
	initial begin
		scl = 1'b1;
		#5;
		forever #32 scl = park ? 1'b0 : (run ? ~scl : 1'b1);
	end
endmodule // scl_host_model

// ===== tb/vcm_mode_ctrl_bench.sv
`timescale 1ns/1ps

// Mode controller bench: register traffic, faults and serial clock parking
module vcm_mode_ctrl_bench
	import vcm_mode_pkg::*;
;
	localparam int LOW = 40;
	logic        clk, reset_n, run, park, scl, rvalid, drv, ring;
	reg_req_t    req;
	fault_t      faults;
	op_mode_t    mode;
	logic [7:0]  rdata, code, hz, code_w, mcfg;
	logic [9:0]  cur;
	logic [2:0]  status;
	logic [31:0] lfsr;
	int          n_errors, n_checks, i;

	scl_host_model host (.run(run), .park(park), .scl(scl));
	vcm_mode_ctrl #(.LOW_CYCLES(LOW)) dut (.clk(clk), .reset_n(reset_n), .scl_pin(scl),
		.reg_req(req), .faults(faults), .reg_rdata(rdata), .reg_rvalid(rvalid), .mode(mode),
		.driver_enable(drv), .current_setpoint(cur), .ring_enable(ring), .mode_config(mcfg),
		.resonance_frequency_code(code), .resonance_hz(hz), .status(status));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	// Frequency for a code: one step per table entry not above it
	function automatic logic [7:0] hz_of(input logic [7:0] c);
		hz_of = 8'h31;
		for (int k = 0; k < RES_TABLE_LEN; k++)
			if (RES_CODE_TABLE[k] <= c) hz_of++;
	endfunction

	function automatic logic [31:0] step(input logic [31:0] s);
		step = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic wrap_up;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One request cycle; results are settled 1 ns after the taking edge
	task automatic req_cycle(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1 req = '{w, r, a, d};
		@(posedge clk);
		#1 req = '0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		req_cycle(1'b0, 1'b1, a, 8'h00);
		chk("rvalid", 1'b1, rvalid);
		chk("rdata", exp, rdata);
	endtask

	// Bounded wait; a spent bound is a mismatch and ends the run
	task automatic wait_mode(input op_mode_t m, input int lim);
		i = 0;
		while (mode !== m && i < lim) begin
			@(posedge clk);
			#1 i++;
		end
		chk("mode wait", m, mode);
		if (mode !== m) wrap_up();
	endtask

	initial begin
		reset_n = 1'b0;
		run = 1'b0;
		park = 1'b0;
		req = '0;
		faults = '0;
		lfsr = 32'h7b9fdbca;
		n_errors = 0;
		n_checks = 0;
		repeat (12) @(posedge clk);
		#1 reset_n = 1'b1;
		run = 1'b1;
		chk("mode", MODE_STANDBY, mode);
		rd(REG_RES_FREQ, RES_FREQ_RESET);
		rd(REG_CONTROL, CONTROL_RESET);
		// Code map: both ends, a step edge, then random codes
		for (int k = 0; k < 24; k++) begin
			lfsr = step(lfsr);
			code_w = k == 0 ? 8'h00 : k == 1 ? 8'hff : k == 2 ? 8'h07 : k == 3 ? 8'h06 : lfsr[7:0];
			req_cycle(1'b1, 1'b0, REG_RES_FREQ, code_w);
			@(posedge clk);
			#1 chk("resonance_hz", hz_of(code_w), hz);
			if (k == 0) chk("low_hz", 8'h32, hz);
			if (k == 1) chk("top_hz", 8'h96, hz);
			rd(REG_RES_FREQ, code_w);
		end
		// Each fault kind drops active; re-entry clears status
		for (int f = 0; f < 3; f++) begin
			lfsr = step(lfsr);
			req_cycle(1'b1, 1'b0, REG_CURRENT_LSB, lfsr[7:0] | 8'h01);
			chk("mode", MODE_ACTIVE, mode);
			chk("status", 3'h0, status);
			req_cycle(1'b1, 1'b0, REG_CURRENT_MSB, {6'h00, lfsr[9:8]});
			chk("current", {lfsr[9:8], lfsr[7:0] | 8'h01}, cur);
			chk("driver", 1'b1, drv);
			@(posedge clk);
			#1 faults = 3'b100 >> f;
			@(posedge clk);
			#1 faults = '0;
			chk("mode", MODE_STANDBY, mode);
			chk("current", 10'h000, cur);
			chk("status", 3'b001 << f, status);
			chk("driver", 1'b0, drv);
			rd(REG_STATUS, 8'h01 << f);
		end
		// Zero setpoint returns to standby
		req_cycle(1'b1, 1'b0, REG_CURRENT_LSB, 8'h05);
		req_cycle(1'b1, 1'b0, REG_CURRENT_LSB, 8'h00);
		chk("mode", MODE_STANDBY, mode);
		chk("driver", 1'b0, drv);
		// Soft reset from active restores defaults and self-clears
		req_cycle(1'b1, 1'b0, REG_RES_FREQ, 8'h10);
		req_cycle(1'b1, 1'b0, REG_CURRENT_LSB, 8'h09);
		lfsr = step(lfsr);
		req_cycle(1'b1, 1'b0, REG_MODE, lfsr[7:0] | 8'h01);
		chk("mode_config", lfsr[7:0] | 8'h01, mcfg);
		req_cycle(1'b1, 1'b0, REG_CONTROL, 8'h00);
		chk("ring", 1'b0, ring);
		rd(REG_CONTROL, 8'h00);
		req_cycle(1'b1, 1'b0, REG_CONTROL, 8'h01);
		chk("mode", MODE_STANDBY, mode);
		chk("current", 10'h000, cur);
		chk("code", RES_FREQ_RESET, code);
		chk("mode_config", MODE_RESET, mcfg);
		chk("ring", CONTROL_RESET[CTRL_RING_BIT], ring);
		rd(REG_CONTROL, CONTROL_RESET);
		// Low time restarts on a high, then expires into shutdown
		req_cycle(1'b1, 1'b0, REG_RES_FREQ, 8'h20);
		req_cycle(1'b1, 1'b0, REG_CURRENT_LSB, 8'h03);
		req_cycle(1'b1, 1'b0, REG_MODE, 8'h5a);
		req_cycle(1'b1, 1'b0, REG_CONTROL, 8'h00);
		run = 1'b0;
		park = 1'b1;
		repeat (30) @(posedge clk);
		#1 park = 1'b0;
		repeat (8) @(posedge clk);
		#1 park = 1'b1;
		repeat (LOW - 12) @(posedge clk);
		#1 chk("mode", MODE_ACTIVE, mode);
		wait_mode(MODE_SHUTDOWN, 30);
		req_cycle(1'b1, 1'b0, REG_CURRENT_LSB, 8'h07);
		req_cycle(1'b0, 1'b1, REG_RES_FREQ, 8'h00);
		chk("rvalid", 1'b0, rvalid);
		chk("mode", MODE_SHUTDOWN, mode);
		chk("current", 10'h003, cur);
		park = 1'b0;
		wait_mode(MODE_STANDBY, 16);
		chk("code", RES_FREQ_RESET, code);
		chk("current", 10'h000, cur);
		chk("mode_config", MODE_RESET, mcfg);
		chk("ring", CONTROL_RESET[CTRL_RING_BIT], ring);
		run = 1'b1;
		rd(REG_RES_FREQ, RES_FREQ_RESET);
		wrap_up();
	end
endmodule // vcm_mode_ctrl_bench
